// file: common/pic_pkg.sv
// constants and types shared by the priority interrupt controller
package pic_pkg;
    localparam int unsigned PIC_VEC_W      = 9;
    localparam int unsigned PIC_PRI_W      = 4;
    localparam int unsigned PIC_NUM_LEVELS = 16;
    localparam int unsigned PIC_NUM_SRC    = 32;
    localparam int unsigned PIC_STACK_D    = 16;
    localparam logic [PIC_PRI_W-1:0] PIC_PRI_RST   = 4'h0;
    localparam logic [PIC_VEC_W-1:0] PIC_VEC_BASE  = 9'h000;

    typedef logic [PIC_PRI_W-1:0] pic_pri_t;
    typedef logic [PIC_VEC_W-1:0] pic_vec_t;
endpackage : pic_pkg

// file: common/pic_arb_if.sv
// link between the controller and its arbitration tree
`timescale 1ns/1ps
interface pic_arb_if #(parameter int unsigned N = 32) ();
    import pic_pkg::*;
    logic     [N-1:0] pend;
    pic_pri_t         pri [N];
    logic             win_valid;
    pic_pri_t         win_pri;
    pic_vec_t         win_vec;
    modport ctrl (output pend, output pri, input win_valid, input win_pri, input win_vec);
    modport arb  (input pend, input pri, output win_valid, output win_pri, output win_vec);
endinterface : pic_arb_if

// file: rtl/pic_arbiter.sv
// combinational priority arbiter with fixed tie-break order
`timescale 1ns/1ps
module pic_arbiter
    import pic_pkg::*;
#(
    parameter int unsigned N = PIC_NUM_SRC
) (
    pic_arb_if.arb arb
);
    always_comb begin
        arb.win_valid = 1'b0;
        arb.win_pri   = PIC_PRI_RST;
        arb.win_vec   = PIC_VEC_BASE;
        // strict greater-than keeps the lowest index among equal levels
        for (int i = 0; i < N; i++) begin
            if (arb.pend[i] && (!arb.win_valid || arb.pri[i] > arb.win_pri)) begin
                arb.win_valid = 1'b1;
                arb.win_pri   = arb.pri[i];
                arb.win_vec   = PIC_VEC_BASE + pic_vec_t'(i);
            end
        end
    end
endmodule : pic_arbiter

// file: rtl/pic_ctrl.sv
// priority interrupt controller for one processor core
`timescale 1ns/1ps
module pic_ctrl
    import pic_pkg::*;
#(
    parameter int unsigned N = PIC_NUM_SRC,
    parameter int unsigned D = PIC_STACK_D
) (
    input  wire logic           i_clk_sys,
    input  wire logic           i_rst_n,
    input  wire logic [N-1:0]   i_irq,
    input  wire logic           i_pri_we,
    input  wire logic [8:0]     i_pri_sel,
    input  wire pic_pri_t       i_pri_wdata,
    input  wire logic           i_mask_we,
    input  wire pic_pri_t       i_mask_wdata,
    input  wire logic           i_ack,
    input  wire logic           i_eoi,
    output logic                o_irq_req,
    output pic_vec_t            o_irq_vec,
    output pic_pri_t            o_cur_pri,
    output pic_pri_t            o_ack_pri
);
    // =========================================================
    // helpers
    localparam int unsigned SW = $clog2(N);
    localparam int unsigned DW = $clog2(D);

    // source index behind a vector
    function automatic logic [SW-1:0] src_of(input pic_vec_t v);
        pic_vec_t off;
        off = v - PIC_VEC_BASE;
        return off[SW-1:0];
    endfunction : src_of

    // priority select that names a real source
    function automatic logic sel_ok(input logic [8:0] s);
        return s < 9'(N);
    endfunction : sel_ok

    // true when level a beats level b
    function automatic logic above(input pic_pri_t a, input pic_pri_t b);
        return a > b;
    endfunction : above

    // =========================================================
    // input synchronisers
    logic [N-1:0] irq_m_q, irq_s_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_m_q <= '0;
            irq_s_q <= '0;
        end else begin
            irq_m_q <= i_irq;
            irq_s_q <= irq_m_q;
        end
    end

    // =========================================================
    // state
    pic_pri_t         pri_q [N];
    pic_pri_t         pri_d [N];
    pic_pri_t         cur_q, cur_d;
    pic_pri_t         stk_q [D];
    pic_pri_t         stk_d [D];
    logic [4:0]       sp_q, sp_d;
    logic [N-1:0]     inserv_q, inserv_d;
    logic             req_q, req_d;
    pic_vec_t         vec_q, vec_d;
    pic_pri_t         ackp_q, ackp_d;
    logic             take;

    pic_arb_if #(.N(N)) arb_bus ();
    // private arbitration: nothing here is shared with the copy serving another core
    pic_arbiter #(.N(N)) u_arb (.arb(arb_bus.arb));

    always_comb begin
        for (int i = 0; i < N; i++) begin
            arb_bus.pend[i] = irq_s_q[i] && !inserv_q[i];
            arb_bus.pri[i]  = pri_q[i];
        end
    end

    // =========================================================
    // priority table
    always_comb begin
        pri_d = pri_q;
        // out-of-range selects are dropped rather than folded onto a real source
        if (i_pri_we && sel_ok(i_pri_sel))
            pri_d[i_pri_sel[SW-1:0]] = i_pri_wdata;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < N; i++) pri_q[i] <= PIC_PRI_RST;
        end else begin
            pri_q <= pri_d;
        end
    end

    // =========================================================
    // running level and its save stack
    always_comb begin
        cur_d    = cur_q;
        stk_d    = stk_q;
        sp_d     = sp_q;
        inserv_d = inserv_q;
        take     = i_ack && req_q;
        // a full stack refuses the push; the request drops and comes back next cycle
        if (take && sp_q < 5'(D)) begin
            stk_d[sp_q[DW-1:0]]     = cur_q;
            sp_d                    = sp_q + 5'h01;
            cur_d                   = ackp_q;
            inserv_d[src_of(vec_q)] = 1'b1;
        end else if (i_eoi && sp_q != 5'h00) begin
            sp_d     = sp_q - 5'h01;
            cur_d    = stk_q[sp_d[DW-1:0]];
            // sources drop their lines before end of service, so all marks clear at once
            inserv_d = '0;
        end else if (i_mask_we) begin
            cur_d    = i_mask_wdata;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < D; i++) stk_q[i] <= PIC_PRI_RST;
            cur_q    <= PIC_PRI_RST;
            sp_q     <= 5'h00;
            inserv_q <= '0;
        end else begin
            stk_q    <= stk_d;
            cur_q    <= cur_d;
            sp_q     <= sp_d;
            inserv_q <= inserv_d;
        end
    end

    // =========================================================
    // request towards the core
    always_comb begin
        ackp_d = ackp_q;
        vec_d  = vec_q;
        // strictly above the running level only, so the mask blocks equal levels
        req_d  = arb_bus.win_valid && above(arb_bus.win_pri, cur_d) && !take;
        // vector and level move only with a fresh request, so an ack always pairs them
        if (req_d) begin
            vec_d  = arb_bus.win_vec;
            ackp_d = arb_bus.win_pri;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_q  <= 1'b0;
            vec_q  <= PIC_VEC_BASE;
            ackp_q <= PIC_PRI_RST;
        end else begin
            req_q  <= req_d;
            vec_q  <= vec_d;
            ackp_q <= ackp_d;
        end
    end

    assign o_irq_req = req_q;
    assign o_irq_vec = vec_q;
    assign o_cur_pri = cur_q;
    assign o_ack_pri = ackp_q;

    // =========================================================
    // arbitration cross-check
    // an independent scan for any pending source that should have beaten the winner
    logic beat_err;
    always_comb begin
        beat_err = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (arb_bus.pend[i] && above(arb_bus.pri[i], arb_bus.win_pri))
                beat_err = 1'b1;
            if (arb_bus.pend[i] && arb_bus.pri[i] == arb_bus.win_pri && i < int'(src_of(arb_bus.win_vec)))
                beat_err = 1'b1;
        end
    end

    // =========================================================
    // checks
    req_above_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n) o_irq_req |-> o_ack_pri > $past(cur_d))
        else $error("request not above level");
    stale_req_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n) o_irq_req |-> !inserv_q[src_of(o_irq_vec)])
        else $error("request for a source in service");
    ack_drop_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n) (i_ack && o_irq_req) |=> !o_irq_req)
        else $error("req after ack");

    vec_range_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n) o_irq_req |-> (o_irq_vec - PIC_VEC_BASE) < 9'(N))
        else $error("vector outside source range");
    fixed_tie_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n) arb_bus.win_valid |-> !beat_err)
        else $error("arbitration winner beaten");
    pri_write_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_pri_we && sel_ok(i_pri_sel)) |=> pri_q[$past(i_pri_sel[SW-1:0])] == $past(i_pri_wdata))
        else $error("priority write lost");

    mask_set_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_mask_we && !i_ack && !i_eoi) |=> o_cur_pri == $past(i_mask_wdata))
        else $error("mask lost");
    level_hold_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (!i_mask_we && !i_eoi && !(i_ack && o_irq_req)) |=> $stable(o_cur_pri))
        else $error("level moved without cause");

    ack_raise_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_ack && o_irq_req && sp_q < 5'(D)) |=> o_cur_pri == $past(o_ack_pri))
        else $error("ack no raise");
    eoi_pop_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_eoi && !(i_ack && o_irq_req) && sp_q != 5'h00) |=> sp_q == $past(sp_q) - 5'h01)
        else $error("eoi");
    stack_bound_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n) sp_q <= 5'(D))
        else $error("stack pointer past depth");
endmodule : pic_ctrl

// file: test/pic_core_model.sv
// core model that takes each presented request
`timescale 1ns/1ps
module pic_core_model (
    input  wire logic i_clk_sys,
    input  wire logic i_hold,
    input  wire logic i_irq_req,
    output logic      o_ack
);
    // one pulse per request; hold lets the bench play a slow core
    always @(negedge i_clk_sys) begin
        o_ack <= i_irq_req && !i_hold && !o_ack;
    end
endmodule : pic_core_model

// file: test/test_priority_interrupt_controller.sv
// self-checking bench for the priority interrupt controller
`timescale 1ns/1ps
module test_priority_interrupt_controller;
    import pic_pkg::*;
    logic        clk = 0, rst_n = 0, pwe = 0, mwe = 0, eoi = 0, hold = 1, ack, req;
    logic [31:0] irq = '0;
    logic [8:0]  sel = '0;
    pic_pri_t    wd = '0, r, cur, apri;
    pic_vec_t    vec;
    logic [12:0] expq [$];
    int          fail_count = 0, tests_run = 0, seed = 46;
    always #12.5 clk = ~clk;
    pic_ctrl dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_irq(irq), .i_pri_we(pwe), .i_pri_sel(sel),
        .i_pri_wdata(wd), .i_mask_we(mwe), .i_mask_wdata(wd), .i_ack(ack), .i_eoi(eoi),
        .o_irq_req(req), .o_irq_vec(vec), .o_cur_pri(cur), .o_ack_pri(apri));
    pic_core_model core (.i_clk_sys(clk), .i_hold(hold), .i_irq_req(req), .o_ack(ack));
    task automatic chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    task automatic wr(input logic m, input int s, input pic_pri_t p);
        @(negedge clk);
        sel = s[8:0];
        wd = p;
        pwe = !m;
        mwe = m;
        @(negedge clk);
        pwe = 0;
        mwe = 0;
    endtask : wr
    task automatic done();
        @(negedge clk);
        eoi = 1;
        @(negedge clk);
        eoi = 0;
    endtask : done
    // note the expected answer before the core is let go
    task automatic take(input int s, input pic_pri_t p);
        expq.push_back({s[8:0], p});
        hold <= 1'b0;
        for (int i = 0; i < 20 && expq.size() != 0; i++) @(negedge clk);
        hold <= 1'b1;
        if (expq.size() != 0) begin
            fail_count++;
            summarize();
        end
    endtask : take
    // ======================================
    // watcher
    always @(posedge clk) begin
        if (ack && req && expq.size() != 0) chk("vector and level", {vec, apri}, expq.pop_front());
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        chk("idle request", 13'(req), 13'h0000);
        r = 4'h6 + 4'($unsigned($random(seed)) % 10);
        wr(0, 3, 4'h5);
        wr(0, 259, 4'hf);
        wr(0, 9, 4'h5);
        wr(0, 20, r);
        irq[9] = 1;
        irq[3] = 1;
        take(3, 4'h5);
        chk("level after take", 13'(cur), 13'h0005);
        irq[20] = 1;
        take(20, r);
        chk("nested level", 13'(cur), 13'(r));
        irq[20] = 0;
        irq[3] = 0;
        repeat (4) @(negedge clk);
        chk("lower waits", 13'(req), 13'h0000);
        done();
        chk("restored level", 13'(cur), 13'h0005);
        done();
        take(9, 4'h5);
        irq[9] = 0;
        done();
        wr(1, 0, 4'hf);
        irq[20] = 1;
        repeat (6) @(negedge clk);
        chk("masked request", 13'(req), 13'h0000);
        wr(1, 0, 4'h0);
        take(20, r);
        summarize();
    end
endmodule : test_priority_interrupt_controller
